//--- design/ifs_fifo_status_flush_ctrl.sv
// Two-wire controller FIFO status, transmit flush and shared line reset.
// Holds the four two-byte FIFOs, a start/stop detector with the bus busy
// flag, and the Wishbone slave that exposes them to software.
// Assumes a classic Wishbone master on clk_sys_i and the serial lines
// arriving asynchronously from the pads.
`timescale 1ns/1ps
module ifs_fifo_status_flush_ctrl
    import ifs_pkg::*;
#(
    parameter int FIFO_DEPTH = IFS_FIFO_DEPTH,
    parameter int BYTE_W = IFS_BYTE_W
) (
    input wire logic clk_sys_i,
    input wire logic rst_n_i,
    // Classic Wishbone slave.
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [IFS_ADR_W-1:0] wb_adr_i,
    input wire logic [IFS_SEL_W-1:0] wb_sel_i,
    input wire logic [IFS_DAT_W-1:0] wb_dat_i,
    output logic [IFS_DAT_W-1:0] wb_dat_o,
    output logic wb_ack_o,
    // Master transmit FIFO.
    input wire logic mtx_push_i,
    input wire logic [BYTE_W-1:0] mtx_push_data_i,
    output logic mtx_push_ready_o,
    input wire logic mtx_pop_i,
    output logic [BYTE_W-1:0] mtx_pop_data_o,
    output logic mtx_pop_valid_o,
    // Master receive FIFO.
    input wire logic mrx_push_i,
    input wire logic [BYTE_W-1:0] mrx_push_data_i,
    output logic mrx_push_ready_o,
    input wire logic mrx_pop_i,
    output logic [BYTE_W-1:0] mrx_pop_data_o,
    output logic mrx_pop_valid_o,
    // Slave transmit FIFO.
    input wire logic stx_push_i,
    input wire logic [BYTE_W-1:0] stx_push_data_i,
    output logic stx_push_ready_o,
    input wire logic stx_pop_i,
    output logic [BYTE_W-1:0] stx_pop_data_o,
    output logic stx_pop_valid_o,
    // Slave receive FIFO.
    input wire logic srx_push_i,
    input wire logic [BYTE_W-1:0] srx_push_data_i,
    output logic srx_push_ready_o,
    input wire logic srx_pop_i,
    output logic [BYTE_W-1:0] srx_pop_data_o,
    output logic srx_pop_valid_o,
    // Serial line levels seen at the pads.
    input wire logic scl_i,
    input wire logic sda_i,
    // Line condition outputs for the master and slave engines.
    output logic start_det_o,
    output logic stop_det_o,
    output logic bus_busy_flag_o,
    output logic slave_tx_empty_flag_o,
    output logic detector_reset_o
);

    localparam int CNT_W = $clog2(FIFO_DEPTH + 1);

    // Packed per-FIFO groups so one generate loop serves all four.
    logic [IFS_NUM_FIFOS-1:0] push;
    logic [IFS_NUM_FIFOS-1:0] pop;
    logic [IFS_NUM_FIFOS-1:0] flush;
    logic [IFS_NUM_FIFOS-1:0] push_ready;
    logic [IFS_NUM_FIFOS-1:0] pop_valid;
    logic [BYTE_W-1:0] push_data [IFS_NUM_FIFOS];
    logic [BYTE_W-1:0] pop_data [IFS_NUM_FIFOS];
    logic [CNT_W-1:0] count [IFS_NUM_FIFOS];
    logic [IFS_LEVEL_W-1:0] level [IFS_NUM_FIFOS];

    logic master_tx_flush;
    logic slave_tx_flush;
    logic shared_reset;

    logic bus_hit;
    logic wr_strobe;
    logic hit_status;
    logic hit_shared;
    logic hit_stretch;
    logic [15:0] status_word;
    logic [IFS_DAT_W-1:0] next_rdata;

    logic [IFS_SYNC_STAGES-1:0] scl_sync;
    logic [IFS_SYNC_STAGES-1:0] sda_sync;
    logic scl_level;
    logic sda_level;
    logic sda_prev;
    logic scl_prev;
    logic det_armed;
    logic start_seen;
    logic stop_seen;
    ifs_line_state_t line_state;

    // ---------------------------------------------------------------
    // FIFO port mapping.
    // ---------------------------------------------------------------
    assign push[IFS_FIFO_MTX] = mtx_push_i;
    assign push[IFS_FIFO_MRX] = mrx_push_i;
    assign push[IFS_FIFO_STX] = stx_push_i;
    assign push[IFS_FIFO_SRX] = srx_push_i;
    assign pop[IFS_FIFO_MTX] = mtx_pop_i;
    assign pop[IFS_FIFO_MRX] = mrx_pop_i;
    assign pop[IFS_FIFO_STX] = stx_pop_i;
    assign pop[IFS_FIFO_SRX] = srx_pop_i;
    assign push_data[IFS_FIFO_MTX] = mtx_push_data_i;
    assign push_data[IFS_FIFO_MRX] = mrx_push_data_i;
    assign push_data[IFS_FIFO_STX] = stx_push_data_i;
    assign push_data[IFS_FIFO_SRX] = srx_push_data_i;

    // Only the two transmit FIFOs can be flushed from software.
    assign flush[IFS_FIFO_MTX] = master_tx_flush;
    assign flush[IFS_FIFO_STX] = slave_tx_flush;
    assign flush[IFS_FIFO_MRX] = 1'b0;
    assign flush[IFS_FIFO_SRX] = 1'b0;

    genvar g;
    generate
        for (g = 0; g < IFS_NUM_FIFOS; g++) begin : g_fifo
            ifs_byte_fifo #(
                .WIDTH(BYTE_W),
                .DEPTH(FIFO_DEPTH),
                .CNT_W(CNT_W)
            ) u_fifo (
                .clk_sys_i(clk_sys_i),
                .rst_n_i(rst_n_i),
                .flush_i(flush[g]),
                .push_i(push[g]),
                .push_data_i(push_data[g]),
                .push_ready_o(push_ready[g]),
                .pop_i(pop[g]),
                .pop_data_o(pop_data[g]),
                .pop_valid_o(pop_valid[g]),
                .count_o(count[g])
            );
            // The count never passes the depth, so code three cannot appear.
            assign level[g] = IFS_LEVEL_W'(count[g]);
        end
    endgenerate

    assign mtx_push_ready_o = push_ready[IFS_FIFO_MTX];
    assign mrx_push_ready_o = push_ready[IFS_FIFO_MRX];
    assign stx_push_ready_o = push_ready[IFS_FIFO_STX];
    assign srx_push_ready_o = push_ready[IFS_FIFO_SRX];
    assign mtx_pop_valid_o = pop_valid[IFS_FIFO_MTX];
    assign mrx_pop_valid_o = pop_valid[IFS_FIFO_MRX];
    assign stx_pop_valid_o = pop_valid[IFS_FIFO_STX];
    assign srx_pop_valid_o = pop_valid[IFS_FIFO_SRX];
    assign mtx_pop_data_o = pop_data[IFS_FIFO_MTX];
    assign mrx_pop_data_o = pop_data[IFS_FIFO_MRX];
    assign stx_pop_data_o = pop_data[IFS_FIFO_STX];
    assign srx_pop_data_o = pop_data[IFS_FIFO_SRX];

    // Taken straight from the count so a flush shows on the very next cycle.
    assign slave_tx_empty_flag_o = (count[IFS_FIFO_STX] == '0);

    // ---------------------------------------------------------------
    // Wishbone slave: ack one cycle after the request, for any address.
    // ---------------------------------------------------------------
    assign bus_hit = wb_cyc_i && wb_stb_i;
    assign wr_strobe = bus_hit && wb_we_i && wb_ack_o;
    assign hit_status = (wb_adr_i == IFS_ADR_FIFO_STATUS);
    assign hit_shared = (wb_adr_i == IFS_ADR_SHARED_CONTROL);
    assign hit_stretch = (wb_adr_i == IFS_ADR_AUTO_STRETCH);

    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            wb_ack_o <= 1'b0;
        end else begin
            wb_ack_o <= bus_hit && !wb_ack_o;
        end
    end

    // Flush bits sit in the status word but always read back as zero.
    always_comb begin
        status_word = IFS_RST_FIFO_STATUS;
        status_word[IFS_BIT_MASTER_TX_FLUSH] = 1'b0;
        status_word[IFS_BIT_SLAVE_TX_FLUSH] = 1'b0;
        status_word[IFS_LSB_MASTER_RX_LEVEL +: IFS_LEVEL_W] =
            level[IFS_FIFO_MRX];
        status_word[IFS_LSB_MASTER_TX_LEVEL +: IFS_LEVEL_W] =
            level[IFS_FIFO_MTX];
        status_word[IFS_LSB_SLAVE_RX_LEVEL +: IFS_LEVEL_W] =
            level[IFS_FIFO_SRX];
        status_word[IFS_LSB_SLAVE_TX_LEVEL +: IFS_LEVEL_W] =
            level[IFS_FIFO_STX];
    end

    always_comb begin
        next_rdata = '0;
        if (hit_status) begin
            next_rdata = {16'h0000, status_word};
        end else if (hit_shared) begin
            // The reset bit is a pulse, so the word always reads as zero.
            next_rdata = {16'h0000, IFS_RST_SHARED_CONTROL};
        end else if (hit_stretch) begin
            // Stretch control lives elsewhere; only the zero word answers.
            next_rdata = {16'h0000, IFS_RST_AUTO_STRETCH};
        end
    end

    // Read data is captured with the ack so it is stable for the master.
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            wb_dat_o <= '0;
        end else if (bus_hit && !wb_ack_o && !wb_we_i) begin
            wb_dat_o <= next_rdata;
        end else if (!bus_hit) begin
            wb_dat_o <= '0;
        end
    end

    // Write-one pulses last exactly one cycle; a zero leaves state alone.
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            master_tx_flush <= 1'b0;
            slave_tx_flush <= 1'b0;
        end else begin
            master_tx_flush <= wr_strobe && hit_status
                && wb_sel_i[IFS_LANE_FLUSH]
                && wb_dat_i[IFS_BIT_MASTER_TX_FLUSH];
            slave_tx_flush <= wr_strobe && hit_status
                && wb_sel_i[IFS_LANE_FLUSH]
                && wb_dat_i[IFS_BIT_SLAVE_TX_FLUSH];
        end
    end

    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            shared_reset <= 1'b0;
        end else begin
            shared_reset <= wr_strobe && hit_shared
                && wb_sel_i[IFS_LANE_SHARED_RESET]
                && wb_dat_i[IFS_BIT_SHARED_RESET];
        end
    end

    assign detector_reset_o = shared_reset;

    // ---------------------------------------------------------------
    // Line synchronisers: a level counts once stages two and three agree.
    // ---------------------------------------------------------------
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            scl_sync <= '1;
            sda_sync <= '1;
        end else begin
            scl_sync <= {scl_sync[IFS_SYNC_STAGES-2:0], scl_i};
            sda_sync <= {sda_sync[IFS_SYNC_STAGES-2:0], sda_i};
        end
    end

    // Disagreement between the last two stages holds the previous level,
    // which filters single-cycle glitches at the cost of one cycle of lag.
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            scl_level <= 1'b1;
            sda_level <= 1'b1;
        end else begin
            if (scl_sync[1] == scl_sync[2]) begin
                scl_level <= scl_sync[2];
            end
            if (sda_sync[1] == sda_sync[2]) begin
                sda_level <= sda_sync[2];
            end
        end
    end

    // ---------------------------------------------------------------
    // Start and stop detection.
    // ---------------------------------------------------------------
    // A shared reset clears the edge history and disarms detection until
    // both lines have been seen high, so a reset taken mid-frame cannot
    // report a false condition from stale history.
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            scl_prev <= 1'b1;
            sda_prev <= 1'b1;
            det_armed <= 1'b0;
        end else if (shared_reset) begin
            scl_prev <= 1'b1;
            sda_prev <= 1'b1;
            det_armed <= 1'b0;
        end else begin
            scl_prev <= scl_level;
            sda_prev <= sda_level;
            if (scl_level && sda_level) begin
                det_armed <= 1'b1;
            end
        end
    end

    assign start_seen = det_armed && !shared_reset && scl_level && scl_prev
        && sda_prev && !sda_level;
    assign stop_seen = det_armed && !shared_reset && scl_level && scl_prev
        && !sda_prev && sda_level;

    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            start_det_o <= 1'b0;
            stop_det_o <= 1'b0;
        end else begin
            start_det_o <= start_seen;
            stop_det_o <= stop_seen;
        end
    end

    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            line_state <= IFS_LINE_IDLE;
        end else begin
            case (line_state)
                IFS_LINE_IDLE: begin
                    if (start_seen) begin
                        line_state <= IFS_LINE_BUSY;
                    end
                end
                IFS_LINE_BUSY: begin
                    if (shared_reset || stop_seen) begin
                        line_state <= IFS_LINE_IDLE;
                    end
                end
                default: begin
                    line_state <= IFS_LINE_IDLE;
                end
            endcase
        end
    end

    assign bus_busy_flag_o = (line_state == IFS_LINE_BUSY);

endmodule

//--- design/ifs_pkg.sv
// Shared constants for the FIFO status, flush and shared reset block.
// Assumes a 32-bit classic Wishbone register bus that carries full addresses.
package ifs_pkg;

    localparam int IFS_ADR_W = 32;
    localparam int IFS_DAT_W = 32;
    localparam int IFS_SEL_W = 4;

    // Register byte addresses.
    localparam logic [31:0] IFS_ADR_FIFO_STATUS = 32'h4000304c;
    localparam logic [31:0] IFS_ADR_SHARED_CONTROL = 32'h40003050;
    localparam logic [31:0] IFS_ADR_AUTO_STRETCH = 32'h40003058;

    // Register reset values.
    localparam logic [15:0] IFS_RST_FIFO_STATUS = 16'h0000;
    localparam logic [15:0] IFS_RST_SHARED_CONTROL = 16'h0000;
    localparam logic [15:0] IFS_RST_AUTO_STRETCH = 16'h0000;

    // Field positions in the FIFO status register.
    localparam int IFS_BIT_MASTER_TX_FLUSH = 9;
    localparam int IFS_BIT_SLAVE_TX_FLUSH = 8;
    localparam int IFS_LSB_MASTER_RX_LEVEL = 6;
    localparam int IFS_LSB_MASTER_TX_LEVEL = 4;
    localparam int IFS_LSB_SLAVE_RX_LEVEL = 2;
    localparam int IFS_LSB_SLAVE_TX_LEVEL = 0;
    localparam int IFS_LEVEL_W = 2;

    // Field position in the shared control register.
    localparam int IFS_BIT_SHARED_RESET = 0;

    // Byte lanes that hold those fields.
    localparam int IFS_LANE_FLUSH = 1;
    localparam int IFS_LANE_SHARED_RESET = 0;

    // FIFO geometry and indices into the FIFO port groups.
    localparam int IFS_NUM_FIFOS = 4;
    localparam int IFS_FIFO_DEPTH = 2;
    localparam int IFS_BYTE_W = 8;
    localparam int IFS_FIFO_MTX = 0;
    localparam int IFS_FIFO_MRX = 1;
    localparam int IFS_FIFO_STX = 2;
    localparam int IFS_FIFO_SRX = 3;

    // Line-synchroniser length.
    localparam int IFS_SYNC_STAGES = 3;

    typedef enum logic {
        IFS_LINE_IDLE,
        IFS_LINE_BUSY
    } ifs_line_state_t;

endpackage

//--- design/ifs_byte_fifo.sv
// Small byte FIFO with a count output and a synchronous flush.
// Assumes the writer and reader share clk_sys_i with the rest of the block.
`timescale 1ns/1ps
module ifs_byte_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 2,
    parameter int CNT_W = 2
) (
    input wire logic clk_sys_i,
    input wire logic rst_n_i,
    input wire logic flush_i,
    input wire logic push_i,
    input wire logic [WIDTH-1:0] push_data_i,
    output logic push_ready_o,
    input wire logic pop_i,
    output logic [WIDTH-1:0] pop_data_o,
    output logic pop_valid_o,
    output logic [CNT_W-1:0] count_o
);

    localparam int PTR_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam logic [CNT_W-1:0] CNT_FULL = CNT_W'(DEPTH);
    localparam logic [PTR_W-1:0] PTR_LAST = PTR_W'(DEPTH - 1);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [PTR_W-1:0] wr_ptr;
    logic [PTR_W-1:0] rd_ptr;
    logic do_push;
    logic do_pop;

    assign push_ready_o = (count_o != CNT_FULL) || flush_i;
    assign pop_valid_o = (count_o != '0);
    // A flush drops stored bytes, but a byte pushed in the same cycle is kept.
    assign do_push = push_i && push_ready_o;
    assign do_pop = pop_i && pop_valid_o && !flush_i;
    assign pop_data_o = mem[rd_ptr];

    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            for (int i = 0; i < DEPTH; i++) begin
                mem[i] <= '0;
            end
        end else if (do_push) begin
            mem[flush_i ? rd_ptr : wr_ptr] <= push_data_i;
        end
    end

    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count_o <= '0;
        end else if (flush_i) begin
            wr_ptr <= do_push ? ((rd_ptr == PTR_LAST) ? '0 : rd_ptr + 1'b1)
                              : rd_ptr;
            count_o <= do_push ? CNT_W'(1) : '0;
        end else begin
            if (do_push) begin
                wr_ptr <= (wr_ptr == PTR_LAST) ? '0 : wr_ptr + 1'b1;
            end
            if (do_pop) begin
                rd_ptr <= (rd_ptr == PTR_LAST) ? '0 : rd_ptr + 1'b1;
            end
            if (do_push && !do_pop) begin
                count_o <= count_o + 1'b1;
            end else if (do_pop && !do_push) begin
                count_o <= count_o - 1'b1;
            end
        end
    end

endmodule

//--- sim/ifs_fifo_status_flush_ctrl_props.sv
// Concurrent checks on the FIFO status, flush and shared reset block.
// Assumes it is bound to the top module and sees only its ports.
`timescale 1ns/1ps
module ifs_fifo_status_flush_ctrl_props
    import ifs_pkg::*;
(
    input wire logic clk_sys_i,
    input wire logic rst_n_i,
    input wire logic wb_we_i,
    input wire logic [IFS_ADR_W-1:0] wb_adr_i,
    input wire logic [IFS_SEL_W-1:0] wb_sel_i,
    input wire logic [IFS_DAT_W-1:0] wb_dat_i,
    input wire logic [IFS_DAT_W-1:0] wb_dat_o,
    input wire logic wb_ack_o,
    input wire logic mtx_push_i,
    input wire logic mtx_pop_valid_o,
    input wire logic stx_push_i,
    input wire logic stx_pop_valid_o,
    input wire logic start_det_o,
    input wire logic stop_det_o,
    input wire logic bus_busy_flag_o,
    input wire logic slave_tx_empty_flag_o,
    input wire logic detector_reset_o
);
    logic wr_st, rd_st, wr_sh, rd_sh;
    assign wr_st = wb_ack_o && wb_we_i && wb_adr_i == IFS_ADR_FIFO_STATUS
        && wb_sel_i[IFS_LANE_FLUSH];
    assign rd_st = wb_ack_o && !wb_we_i && wb_adr_i == IFS_ADR_FIFO_STATUS;
    assign wr_sh = wb_ack_o && wb_we_i && wb_adr_i == IFS_ADR_SHARED_CONTROL
        && wb_sel_i[IFS_LANE_SHARED_RESET];
    assign rd_sh = wb_ack_o && !wb_we_i && wb_adr_i == IFS_ADR_SHARED_CONTROL;

    default clocking cb @(posedge clk_sys_i);
    endclocking
    default disable iff (!rst_n_i);

    // A push in the flush cycle survives, so only a quiet cycle is checked.
    property p_mtx_flush;
        wr_st && wb_dat_i[IFS_BIT_MASTER_TX_FLUSH] ##1 !mtx_push_i
            |=> !mtx_pop_valid_o;
    endproperty
    a_mtx_flush: assert property (p_mtx_flush)
        else $error("master tx FIFO not empty after flush");
    property p_stx_flush;
        wr_st && wb_dat_i[IFS_BIT_SLAVE_TX_FLUSH] ##1 !stx_push_i
            |=> slave_tx_empty_flag_o;
    endproperty
    a_stx_flush: assert property (p_stx_flush)
        else $error("slave tx FIFO not empty after flush");
    property p_empty;
        slave_tx_empty_flag_o == !stx_pop_valid_o;
    endproperty
    a_empty: assert property (p_empty)
        else $error("slave tx empty flag disagrees with FIFO");
    property p_upper;
        wb_ack_o && !wb_we_i |-> wb_dat_o[31:10] == 22'h0;
    endproperty
    a_upper: assert property (p_upper)
        else $error("upper read bits not zero");
    property p_self_clr;
        rd_st |-> wb_dat_o[9:8] == 2'h0;
    endproperty
    a_self_clr: assert property (p_self_clr)
        else $error("flush bits read back nonzero");
    property p_shared_rd;
        rd_sh |-> wb_dat_o == 32'h0;
    endproperty
    a_shared_rd: assert property (p_shared_rd)
        else $error("shared control read nonzero");
    property p_no_three;
        rd_st |-> wb_dat_o[7:6] != 2'h3 && wb_dat_o[5:4] != 2'h3
            && wb_dat_o[3:2] != 2'h3 && wb_dat_o[1:0] != 2'h3;
    endproperty
    a_no_three: assert property (p_no_three)
        else $error("level field reads three");
    property p_det_rst;
        wr_sh && wb_dat_i[IFS_BIT_SHARED_RESET] |-> ##[1:2] detector_reset_o;
    endproperty
    a_det_rst: assert property (p_det_rst)
        else $error("no detector reset after shared reset write");
    property p_busy_clr;
        detector_reset_o |-> ##[0:1] !bus_busy_flag_o;
    endproperty
    a_busy_clr: assert property (p_busy_clr)
        else $error("bus busy not cleared by shared reset");
    property p_busy_rise;
        $rose(bus_busy_flag_o) |-> start_det_o;
    endproperty
    a_busy_rise: assert property (p_busy_rise)
        else $error("bus busy rose without start");
    property p_busy_fall;
        $fell(bus_busy_flag_o) |-> stop_det_o || $past(detector_reset_o);
    endproperty
    a_busy_fall: assert property (p_busy_fall)
        else $error("bus busy fell without stop or shared reset");
endmodule

bind ifs_fifo_status_flush_ctrl ifs_fifo_status_flush_ctrl_props
    ifs_fifo_status_flush_ctrl_props_i (.clk_sys_i(clk_sys_i),
    .rst_n_i(rst_n_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
    .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .mtx_push_i(mtx_push_i),
    .mtx_pop_valid_o(mtx_pop_valid_o), .stx_push_i(stx_push_i),
    .stx_pop_valid_o(stx_pop_valid_o), .start_det_o(start_det_o),
    .stop_det_o(stop_det_o),
    .bus_busy_flag_o(bus_busy_flag_o),
    .slave_tx_empty_flag_o(slave_tx_empty_flag_o),
    .detector_reset_o(detector_reset_o));

//--- sim/test_ifs_fifo_status_flush_ctrl.sv
// Self-checking bench for the FIFO status, flush and shared reset block.
// Assumes the bench alone drives every port; expected reads are queued.
`timescale 1ns/1ps
module test_ifs_fifo_status_flush_ctrl;
    import ifs_pkg::*;
    logic clk_sys_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
    logic [31:0] wb_adr_i = '0, wb_dat_i = '0, wb_dat_o;
    logic [3:0] wb_sel_i = '0;
    logic wb_ack_o, scl_i = 1'b1, sda_i = 1'b1;
    logic push [4] = '{default: 1'b0};
    logic pop [4] = '{default: 1'b0};
    logic [7:0] pdat [4] = '{default: 8'h00};
    logic rdy [4], pv [4];
    logic [7:0] pdo [4];
    logic start_det_o, stop_det_o, bus_busy_flag_o, slave_tx_empty_flag_o;
    logic detector_reset_o;
    logic [31:0] expq [$];
    logic [7:0] dq [4][$];
    int cnt [4] = '{default: 0};
    int n_mismatch = 0, checks_done = 0, cyc = 0;

    always #25 clk_sys_i = ~clk_sys_i;

    ifs_fifo_status_flush_ctrl ifs_fifo_status_flush_ctrl_i (
        .clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .wb_cyc_i(wb_cyc_i),
        .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
        .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
        .wb_ack_o(wb_ack_o), .mtx_push_i(push[0]), .mtx_push_data_i(pdat[0]),
        .mtx_push_ready_o(rdy[0]), .mtx_pop_i(pop[0]),
        .mtx_pop_data_o(pdo[0]), .mtx_pop_valid_o(pv[0]),
        .mrx_push_i(push[1]), .mrx_push_data_i(pdat[1]),
        .mrx_push_ready_o(rdy[1]), .mrx_pop_i(pop[1]),
        .mrx_pop_data_o(pdo[1]), .mrx_pop_valid_o(pv[1]),
        .stx_push_i(push[2]), .stx_push_data_i(pdat[2]),
        .stx_push_ready_o(rdy[2]), .stx_pop_i(pop[2]),
        .stx_pop_data_o(pdo[2]), .stx_pop_valid_o(pv[2]),
        .srx_push_i(push[3]), .srx_push_data_i(pdat[3]),
        .srx_push_ready_o(rdy[3]), .srx_pop_i(pop[3]),
        .srx_pop_data_o(pdo[3]), .srx_pop_valid_o(pv[3]),
        .scl_i(scl_i), .sda_i(sda_i), .start_det_o(start_det_o),
        .stop_det_o(stop_det_o), .bus_busy_flag_o(bus_busy_flag_o),
        .slave_tx_empty_flag_o(slave_tx_empty_flag_o),
        .detector_reset_o(detector_reset_o));

    task automatic end_sim();
        $display("checks %0d mismatches %0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    task automatic cmp(input string what, input logic [31:0] exp,
                       input logic [31:0] seen);
        checks_done++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // One classic cycle; the idle cycle after it keeps requests apart.
    task automatic wb(input logic we, input logic [31:0] adr,
                      input logic [3:0] sel, input logic [31:0] dat);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= adr;
        wb_sel_i <= sel;
        wb_dat_i <= dat;
        do @(posedge clk_sys_i); while (wb_ack_o !== 1'b1);
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        wb_we_i <= 1'b0;
        @(posedge clk_sys_i);
    endtask

    task automatic rd(input logic [31:0] adr, input logic [31:0] exp);
        expq.push_back(exp);
        wb(1'b0, adr, 4'hf, 32'h0);
    endtask

    // Pushes or pops for n cycles; the FIFO drops what it cannot take.
    task automatic fop(input int i, input bit is_pop, input int n);
        logic [7:0] d;
        if (n == 0)
            return;
        repeat (n) begin
            if (is_pop) begin
                pop[i] <= 1'b1;
                cnt[i] = (cnt[i] > 0) ? cnt[i] - 1 : 0;
            end else begin
                d = 8'($urandom);
                push[i] <= 1'b1;
                pdat[i] <= d;
                if (cnt[i] < IFS_FIFO_DEPTH)
                    dq[i].push_back(d);
                cnt[i] = (cnt[i] < IFS_FIFO_DEPTH) ? cnt[i] + 1 : cnt[i];
            end
            @(posedge clk_sys_i);
        end
        push[i] <= 1'b0;
        pop[i] <= 1'b0;
    endtask

    function automatic logic [31:0] stat();
        stat = '0;
        stat[IFS_LSB_MASTER_TX_LEVEL +: 2] = 2'(cnt[IFS_FIFO_MTX]);
        stat[IFS_LSB_MASTER_RX_LEVEL +: 2] = 2'(cnt[IFS_FIFO_MRX]);
        stat[IFS_LSB_SLAVE_TX_LEVEL +: 2] = 2'(cnt[IFS_FIFO_STX]);
        stat[IFS_LSB_SLAVE_RX_LEVEL +: 2] = 2'(cnt[IFS_FIFO_SRX]);
    endfunction

    always @(posedge clk_sys_i) begin
        if (wb_ack_o === 1'b1 && wb_we_i === 1'b0)
            cmp("read data", expq.size() ? expq.pop_front() : ~wb_dat_o,
                wb_dat_o);
    end

    // Bytes popped must leave in push order; a refused push is never noted.
    always @(posedge clk_sys_i) begin
        for (int i = 0; i < 4; i++) begin
            if (pop[i] === 1'b1 && pv[i] === 1'b1)
                cmp("pop data", {24'h0, dq[i].size() ? dq[i].pop_front()
                    : ~pdo[i]}, {24'h0, pdo[i]});
        end
    end

    always @(posedge clk_sys_i) begin
        cyc++;
        if (cyc == 20000) begin
            n_mismatch++;
            end_sim();
        end
    end

    task automatic line_busy(input logic sda, input logic exp);
        sda_i <= sda;
        repeat (10) @(posedge clk_sys_i);
        cmp("bus busy", {31'h0, exp}, {31'h0, bus_busy_flag_o});
    endtask

    initial begin
        logic [31:0] fl;
        void'($urandom(72));
        repeat (20) @(posedge clk_sys_i);
        rst_n_i <= 1'b1;
        @(posedge clk_sys_i);
        rd(IFS_ADR_FIFO_STATUS, {16'h0, IFS_RST_FIFO_STATUS});
        rd(IFS_ADR_SHARED_CONTROL, {16'h0, IFS_RST_SHARED_CONTROL});
        rd(IFS_ADR_AUTO_STRETCH, {16'h0, IFS_RST_AUTO_STRETCH});
        rd(32'h40003054, 32'h0);
        for (int r = 0; r < 8; r++) begin
            for (int i = 0; i < 4; i++)
                fop(i, 1'b0, $urandom % 4);
            rd(IFS_ADR_FIFO_STATUS, stat());
            fop(IFS_FIFO_MRX, 1'b1, $urandom % 2);
            fop(IFS_FIFO_SRX, 1'b1, $urandom % 2);
            // Zero data, or flush bits without their byte lane, change nothing.
            wb(1'b1, IFS_ADR_FIFO_STATUS, r[0] ? 4'h1 : 4'hf,
               r[0] ? 32'h300 : 32'h0);
            rd(IFS_ADR_FIFO_STATUS, stat());
            fl = (r % 3 == 0) ? 32'h200 : (r % 3 == 1) ? 32'h100 : 32'h300;
            // Stands in for the flush software owes after a lost arbitration.
            wb(1'b1, IFS_ADR_FIFO_STATUS, 4'hf, fl);
            if (fl[IFS_BIT_MASTER_TX_FLUSH]) begin
                cnt[IFS_FIFO_MTX] = 0;
                dq[IFS_FIFO_MTX].delete();
            end
            if (fl[IFS_BIT_SLAVE_TX_FLUSH]) begin
                cnt[IFS_FIFO_STX] = 0;
                dq[IFS_FIFO_STX].delete();
            end
            rd(IFS_ADR_FIFO_STATUS, stat());
            cmp("stx empty", {31'h0, cnt[IFS_FIFO_STX] == 0},
                {31'h0, slave_tx_empty_flag_o});
        end
        line_busy(1'b0, 1'b1);
        wb(1'b1, IFS_ADR_SHARED_CONTROL, 4'hf, 32'h1);
        line_busy(1'b0, 1'b0);
        line_busy(1'b1, 1'b0);
        line_busy(1'b0, 1'b1);
        wb(1'b1, IFS_ADR_SHARED_CONTROL, 4'hf, 32'h0);
        line_busy(1'b0, 1'b1);
        rd(IFS_ADR_SHARED_CONTROL, 32'h0);
        line_busy(1'b1, 1'b0);
        end_sim();
    end
endmodule
